// file: sim/cht_host.sv
// two-wire host model reading and writing the bank
`timescale 1ns/1ps
module cht_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    import cht_pkg::*;
    // clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit of an 80 ns clock, sampled mid-high, edges off the core clock edges
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        #23 scl = 1'b1;
        #20 s = sda;
        #20 scl = 1'b0;
        #17;
    endtask
    // start, also used as repeated start
    task automatic start();
        sda_low = 1'b0;
        #23 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #17;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #23 scl = 1'b1;
        #20 sda_low = 1'b0;
        #17;
    endtask
    // byte out msb first, returns the device acknowledge
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // byte in msb first, then acknowledge when more follows
    task automatic get(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!more, s);
    endtask
    // word read: pointer, repeated start, low byte then high byte
    task automatic rd(input logic [7:0] p, output logic [15:0] w, output logic [2:0] acks);
        start();
        put({BUS_ADDRESS, 1'b0}, acks[2]);
        put(p, acks[1]);
        start();
        put({BUS_ADDRESS, 1'b1}, acks[0]);
        get(1'b1, w[7:0]);
        get(1'b0, w[15:8]);
        stop();
    endtask
    // word write to any bus address, returns address acknowledge
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w, output logic ack);
        logic k;
        start();
        put({a, 1'b0}, ack);
        put(p, k);
        put(w[7:0], k);
        put(w[15:8], k);
        stop();
    endtask
endmodule

// file: sim/cht_telemetry_chk.sv
// port assertions for the telemetry bank
`timescale 1ns/1ps
module cht_telemetry_chk #(
    parameter int WARMUP_COUNT = 600000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [cht_pkg::ILIM_W-1:0] iin_limit_target,
    input wire logic charger_enable,
    input wire logic [cht_pkg::CELL_W-1:0] cell_strap,
    input wire logic mppt_enable,
    input wire logic mppt_write,
    input wire logic [cht_pkg::UV_W-1:0] mppt_code,
    input wire logic [cht_pkg::UV_W-1:0] uv_setting,
    input wire logic [cht_pkg::ILIM_W-1:0] input_current_limit_code,
    input wire logic [cht_pkg::UV_W-1:0] input_voltage_floor_code,
    input wire logic [cht_pkg::CELL_W-1:0] cell_count,
    input wire logic charge_allow
);
    import cht_pkg::*;
    logic [31:0] up_reg, up_next;
    // cycles since reset release, saturating
    always_comb begin
        up_next = (up_reg == 32'hffff_ffff) ? up_reg : up_reg + 32'h0000_0001;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 32'h0000_0000;
        end else begin
            up_reg <= up_next;
        end
    end
    // core reset copy is still held for the first edges
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || up_reg < 32'h0000_0004);
    a_ilim_follow: assert property (input_current_limit_code == $past(iin_limit_target))
        else $error("limit code does not follow target");
    a_cell_zero: assert property (!charger_enable |=> cell_count == 4'h0)
        else $error("cell count not zero while disabled");
    a_cell_copy: assert property (charger_enable |=> cell_count == $past(cell_strap))
        else $error("cell count not strap value");
    a_charge_gate: assert property (charge_allow |-> $past(charger_enable))
        else $error("charging allowed while charger disabled");
    a_warm_early: assert property (charge_allow |-> up_reg >= WARMUP_COUNT + 3)
        else $error("charging allowed before warm-up");
    a_warm_late: assert property (up_reg > WARMUP_COUNT + 8 && $past(charger_enable) |-> charge_allow)
        else $error("charging not allowed after warm-up");
    a_uv_follow: assert property ((!mppt_enable && $stable(uv_setting)) [*3] |->
        input_voltage_floor_code == uv_setting)
        else $error("floor code does not follow setting");
    a_mppt_load: assert property (mppt_enable && mppt_write |=> input_voltage_floor_code == $past(mppt_code))
        else $error("tracking write not applied");
    a_mppt_hold: assert property (mppt_enable && !mppt_write |=> $stable(input_voltage_floor_code))
        else $error("floor code moved without tracking write");
endmodule

bind cht_telemetry cht_telemetry_chk #(.WARMUP_COUNT(WARMUP_COUNT)) u_chk (.clock(clock), .rst_n(rst_n),
    .iin_limit_target(iin_limit_target), .charger_enable(charger_enable), .cell_strap(cell_strap),
    .mppt_enable(mppt_enable), .mppt_write(mppt_write), .mppt_code(mppt_code), .uv_setting(uv_setting),
    .input_current_limit_code(input_current_limit_code), .input_voltage_floor_code(input_voltage_floor_code),
    .cell_count(cell_count), .charge_allow(charge_allow));

// file: sim/testbench.sv
// self-checking bench for the telemetry bank
`timescale 1ns/1ps
module testbench;
    import cht_pkg::*;
    localparam int WU = 200;
    logic clock = 1'b0, rst_n = 1'b0, scl, sda_low, sda_out, sda_oe, vv = 1'b0, rt = 1'b0, ce = 1'b1;
    logic me = 1'b0, mw = 1'b0, ca_o;
    logic [5:0] ilim_t = 6'h00, ilim_o;
    logic [7:0] mc = 8'h00, uv = 8'h00, uv_o;
    logic [3:0] cs = 4'h3, cc_o;
    logic signed [15:0] vs = 16'sh0000, ib = 16'sh0000;
    int fails = 0, check_count = 0;
    // open-drain data line with pull-up
    wire logic sda_w = !(sda_low || sda_oe);
    cht_host i_host (.scl(scl), .sda_low(sda_low), .sda(sda_w));
    cht_telemetry #(.WARMUP_COUNT(WU)) i_cht_telemetry (.clock(clock), .rst_n(rst_n), .scl(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .iin_limit_target(ilim_t), .vbat_sample(vs),
        .vbat_sample_valid(vv), .ibat_sample(ib), .resistance_test(rt), .charger_enable(ce), .cell_strap(cs),
        .mppt_enable(me), .mppt_write(mw), .mppt_code(mc), .uv_setting(uv),
        .input_current_limit_code(ilim_o), .input_voltage_floor_code(uv_o), .cell_count(cc_o),
        .charge_allow(ca_o));
    initial begin
        forever #10 clock = !clock;
    end
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // bus read of one word, checks acknowledges and value
    task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
        logic [15:0] w;
        logic [2:0] a;
        i_host.rd(p, w, a);
        cmp("read acks", 16'h0007, {13'h0000, a});
        cmp($sformatf("reg %h", p), e, w);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic t_reset();
        rd_chk(OFS_MEASUREMENT_STATUS, 16'h0000);
        rd_chk(OFS_INPUT_CURRENT_LIMIT_CODE, 16'h0000);
        rd_chk(OFS_FILTERED_BATTERY_VOLTAGE, 16'h0000);
        rd_chk(OFS_RESISTANCE_TEST_CURRENT, 16'h0000);
        rd_chk(OFS_INPUT_VOLTAGE_FLOOR_CODE, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_warm();
        cyc(WU);
        rd_chk(OFS_MEASUREMENT_STATUS, 16'h0001);
        cmp("charge_allow", 16'h0001, {15'h0000, ca_o});
        ce <= 1'b0;
        cyc(3);
        cmp("charge_allow", 16'h0000, {15'h0000, ca_o});
        cmp("cell_count", 16'h0000, {12'h000, cc_o});
        ce <= 1'b1;
        cyc(3);
        cmp("cell_count", 16'h0003, {12'h000, cc_o});
        $display("test warm-up done");
    endtask
    task automatic t_ilim();
        ilim_t <= 6'h3f;
        cyc(3);
        cmp("limit port", 16'h003f, {10'h000, ilim_o});
        rd_chk(OFS_INPUT_CURRENT_LIMIT_CODE, 16'h003f);
        $display("test limit done");
    endtask
    task automatic t_vbat();
        logic signed [15:0] e;
        e = 16'sh0000;
        cyc(1);
        for (int i = 0; i < 3; i++) begin
            vs <= 16'sh1000;
            vv <= 1'b1;
            cyc(1);
            vv <= 1'b0;
            cyc(1);
            e = e + ((16'sh1000 - e) >>> FILTER_SHIFT);
        end
        rd_chk(OFS_FILTERED_BATTERY_VOLTAGE, e);
        $display("test voltage filter done");
    endtask
    task automatic t_bsr();
        logic signed [15:0] v [3] = '{16'sd2183, 16'sd2184, -16'sd5};
        logic q [3] = '{1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++) begin
            cyc(1);
            ib <= v[i];
            rt <= 1'b1;
            cyc(1);
            rt <= 1'b0;
            ib <= 16'sh0000;
            cyc(2);
            rd_chk(OFS_RESISTANCE_TEST_CURRENT, v[i]);
            rd_chk(OFS_MEASUREMENT_STATUS, {14'h0000, q[i], 1'b1});
        end
        $display("test resistance capture done");
    endtask
    task automatic t_uv();
        uv <= 8'ha5;
        cyc(4);
        rd_chk(OFS_INPUT_VOLTAGE_FLOOR_CODE, 16'h00a5);
        cyc(1);
        me <= 1'b1;
        mc <= 8'h3c;
        mw <= 1'b1;
        cyc(1);
        mw <= 1'b0;
        uv <= 8'h5a;
        cyc(4);
        cmp("floor port", 16'h003c, {8'h00, uv_o});
        rd_chk(OFS_INPUT_VOLTAGE_FLOOR_CODE, 16'h003c);
        $display("test floor code done");
    endtask
    task automatic t_ro();
        logic k;
        i_host.wr(BUS_ADDRESS, OFS_INPUT_CURRENT_LIMIT_CODE, 16'hffff, k);
        cmp("write ack", 16'h0001, {15'h0000, k});
        rd_chk(OFS_INPUT_CURRENT_LIMIT_CODE, 16'h003f);
        rd_chk(8'h49, 16'h0000);
        i_host.wr(BUS_ADDRESS ^ 7'h01, OFS_MEASUREMENT_STATUS, 16'h0000, k);
        cmp("foreign address ack", 16'h0000, {15'h0000, k});
        cmp("sda_out", 16'h0000, {15'h0000, sda_out});
        $display("test read-only done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run time
    initial begin
        #400000;
        fails++;
        final_report();
    end
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        cyc(2);
        t_reset();
        t_warm();
        t_ilim();
        t_vbat();
        t_bsr();
        t_uv();
        t_ro();
        final_report();
    end
endmodule

// file: verilog/cht_pkg.sv
// constants for the charger telemetry readback bank
package cht_pkg;
    // register pointer values
    localparam logic [7:0] OFS_INPUT_CURRENT_LIMIT_CODE = 8'h46;
    localparam logic [7:0] OFS_FILTERED_BATTERY_VOLTAGE = 8'h47;
    localparam logic [7:0] OFS_RESISTANCE_TEST_CURRENT = 8'h48;
    localparam logic [7:0] OFS_MEASUREMENT_STATUS = 8'h4a;
    localparam logic [7:0] OFS_INPUT_VOLTAGE_FLOOR_CODE = 8'h4b;
    // field widths and positions
    localparam int ILIM_W = 6;
    localparam int UV_W = 8;
    localparam int CELL_W = 4;
    localparam int STAT_QUEST_BIT = 1;
    localparam int STAT_VALID_BIT = 0;
    // reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [5:0] ILIM_RESET = 6'h00;
    localparam logic [7:0] UV_RESET = 8'h00;
    localparam logic [3:0] CELL_RESET = 4'h0;
    // low-current threshold for the resistance test, 2184 counts
    localparam logic signed [15:0] LOW_CURRENT_THRESHOLD = 16'sh0888;
    // battery voltage filter: new = old + (sample - old) / 2^FILTER_SHIFT
    localparam int FILTER_SHIFT = 3;
    // amplifier warm-up time
    localparam int CLOCK_HZ = 50_000_000;
    localparam int WARMUP_MS = 12;
    localparam int WARMUP_CYCLES = (WARMUP_MS * (CLOCK_HZ / 1000));
    localparam int WARMUP_CNT_W = 20;
    // bus address of the bank, value is arbitrary
    localparam logic [6:0] BUS_ADDRESS = 7'h68;
    // link state machine
    typedef enum logic [3:0] {
        LS_IDLE = 4'b0000,
        LS_ADDR = 4'b0001,
        LS_ADDR_ACK = 4'b0010,
        LS_PTR = 4'b0011,
        LS_PTR_ACK = 4'b0100,
        LS_WDATA = 4'b0101,
        LS_WDATA_ACK = 4'b0110,
        LS_RDATA = 4'b0111,
        LS_RDATA_ACK = 4'b1000
    } cht_link_state_t;
endpackage

// file: verilog/cht_telemetry.sv
// charger telemetry readback bank with its two-wire serial slave
`timescale 1ns/1ps

// Functional notes
// - applied input current limit code follows the software requested limit setting.
// - regulated input current is (code + 1) x 500 uV over the input sense resistor.
// - filtered battery voltage is a signed 16-bit digital filter of voltage conversions.
// - one filtered voltage count is cell count x 192.4 uV at battery sense pin.
// - resistance test latches the present battery current sample until the next test.
// - one captured current count is 1.466 uV over the battery sense resistor.
// - low-current threshold of 2184 counts judges resistance test signal level.
// - status bit 1 set when last test current was below threshold, else cleared.
// - status bit 0 sets only after about 12 ms amplifier warm-up.
// - charging stays disabled until the settled flag is set.
// - eight-bit undervoltage code; regulation voltage is (code + 1) x 140.625 mV.
// - tracking enabled writes the undervoltage code; otherwise it follows the setting.
// - reported cell count is zero whenever the charger is not enabled.
module cht_telemetry #(
    parameter int WARMUP_COUNT = cht_pkg::WARMUP_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [cht_pkg::ILIM_W-1:0] iin_limit_target,
    input wire logic signed [15:0] vbat_sample,
    input wire logic vbat_sample_valid,
    input wire logic signed [15:0] ibat_sample,
    input wire logic resistance_test,
    input wire logic charger_enable,
    input wire logic [cht_pkg::CELL_W-1:0] cell_strap,
    input wire logic mppt_enable,
    input wire logic mppt_write,
    input wire logic [cht_pkg::UV_W-1:0] mppt_code,
    input wire logic [cht_pkg::UV_W-1:0] uv_setting,
    output logic [cht_pkg::ILIM_W-1:0] input_current_limit_code,
    output logic [cht_pkg::UV_W-1:0] input_voltage_floor_code,
    output logic [cht_pkg::CELL_W-1:0] cell_count,
    output logic charge_allow
);
    import cht_pkg::*;

    // ---------------- core domain ----------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [ILIM_W-1:0] ilim_reg, ilim_next;
    logic signed [15:0] vfilt_reg, vfilt_next;
    logic signed [15:0] test_current_reg, test_current_next;
    logic quest_reg, quest_next;
    logic valid_reg, valid_next;
    logic [WARMUP_CNT_W-1:0] warm_cnt_reg, warm_cnt_next;
    logic [UV_W-1:0] uv_reg, uv_next;
    logic [CELL_W-1:0] cell_reg, cell_next;
    logic allow_reg, allow_next;
    logic req_meta_reg, req_sync_reg, req_seen_reg;
    logic [15:0] snap_reg, snap_next;
    logic signed [16:0] vdiff;
    logic signed [16:0] vstep;
    // link domain signals read by the core
    logic req_tog_reg;
    logic [7:0] pointer_reg;

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // next values of the telemetry registers
    always_comb begin
        ilim_next = iin_limit_target;
        vdiff = 17'(vbat_sample) - 17'(vfilt_reg);
        vstep = vdiff >>> FILTER_SHIFT;
        vfilt_next = vfilt_reg;
        if (vbat_sample_valid) begin
            vfilt_next = 16'(17'(vfilt_reg) + vstep);
        end
        test_current_next = test_current_reg;
        quest_next = quest_reg;
        if (resistance_test) begin
            test_current_next = ibat_sample;
            quest_next = (ibat_sample < LOW_CURRENT_THRESHOLD);
        end
        warm_cnt_next = warm_cnt_reg;
        valid_next = valid_reg;
        if (!valid_reg) begin
            if (32'(warm_cnt_reg) >= WARMUP_COUNT - 1) begin
                valid_next = 1'b1;
            end else begin
                warm_cnt_next = warm_cnt_reg + 1'b1;
            end
        end
        allow_next = valid_reg & charger_enable;
        uv_next = uv_reg;
        if (!mppt_enable) begin
            uv_next = uv_setting;
        end else if (mppt_write) begin
            uv_next = mppt_code;
        end
        cell_next = charger_enable ? cell_strap : CELL_RESET;
    end

    // telemetry registers
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ilim_reg <= ILIM_RESET;
            vfilt_reg <= WORD_RESET;
            test_current_reg <= WORD_RESET;
            quest_reg <= 1'b0;
            valid_reg <= 1'b0;
            warm_cnt_reg <= '0;
            uv_reg <= UV_RESET;
            cell_reg <= CELL_RESET;
            allow_reg <= 1'b0;
        end else begin
            ilim_reg <= ilim_next;
            vfilt_reg <= vfilt_next;
            test_current_reg <= test_current_next;
            quest_reg <= quest_next;
            valid_reg <= valid_next;
            warm_cnt_reg <= warm_cnt_next;
            uv_reg <= uv_next;
            cell_reg <= cell_next;
            allow_reg <= allow_next;
        end
    end

    // snapshot of the pointed register, refreshed on each link request
    always_comb begin
        snap_next = snap_reg;
        if (req_sync_reg != req_seen_reg) begin
            case (pointer_reg)
                OFS_INPUT_CURRENT_LIMIT_CODE: snap_next = {10'h000, ilim_reg};
                OFS_FILTERED_BATTERY_VOLTAGE: snap_next = vfilt_reg;
                OFS_RESISTANCE_TEST_CURRENT: snap_next = test_current_reg;
                OFS_MEASUREMENT_STATUS: snap_next = {14'h0000, quest_reg, valid_reg};
                OFS_INPUT_VOLTAGE_FLOOR_CODE: snap_next = {8'h00, uv_reg};
                default: snap_next = WORD_RESET;
            endcase
        end
    end

    // request toggle synchroniser and snapshot register
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            snap_reg <= WORD_RESET;
        end else begin
            req_meta_reg <= req_tog_reg;
            req_sync_reg <= req_meta_reg;
            req_seen_reg <= req_sync_reg;
            snap_reg <= snap_next;
        end
    end

    assign input_current_limit_code = ilim_reg;
    assign input_voltage_floor_code = uv_reg;
    assign cell_count = cell_reg;
    assign charge_allow = allow_reg;

    // ---------------- link domain ----------------
    logic start_tog_reg;
    logic start_seen_reg, start_seen_next;
    cht_link_state_t state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] pointer_next;
    logic req_tog_next;
    logic byte_sel_reg, byte_sel_next;
    logic rw_reg, rw_next;
    logic oe_reg, oe_next;
    logic out_reg;
    logic [7:0] tx_byte;

    // start condition: data falls while the serial clock is high
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tog_reg <= 1'b0;
        end else if (scl) begin
            start_tog_reg <= ~start_tog_reg;
        end
    end

    // protocol next state, sampled on the rising serial clock
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = {shift_reg[6:0], sda_in};
        pointer_next = pointer_reg;
        req_tog_next = req_tog_reg;
        byte_sel_next = byte_sel_reg;
        rw_next = rw_reg;
        start_seen_next = start_tog_reg;
        if (start_tog_reg != start_seen_reg) begin
            state_next = LS_ADDR;
            bit_cnt_next = 3'd1;
        end else begin
            case (state_reg)
                LS_IDLE: begin
                    bit_cnt_next = 3'd0;
                end
                LS_ADDR: begin
                    bit_cnt_next = bit_cnt_reg + 3'd1;
                    if (bit_cnt_reg == 3'd7) begin
                        rw_next = sda_in;
                        if (shift_reg[6:0] == BUS_ADDRESS) begin
                            state_next = LS_ADDR_ACK;
                        end else begin
                            state_next = LS_IDLE;
                        end
                    end
                end
                LS_ADDR_ACK: begin
                    // address acknowledged for both directions; reads start on the low byte
                    bit_cnt_next = 3'd0;
                    byte_sel_next = 1'b0;
                    state_next = rw_reg ? LS_RDATA : LS_PTR;
                end
                LS_PTR: begin
                    bit_cnt_next = bit_cnt_reg + 3'd1;
                    if (bit_cnt_reg == 3'd7) begin
                        pointer_next = {shift_reg[6:0], sda_in};
                        req_tog_next = ~req_tog_reg;
                        state_next = LS_PTR_ACK;
                    end
                end
                LS_PTR_ACK: begin
                    bit_cnt_next = 3'd0;
                    state_next = LS_WDATA;
                end
                LS_WDATA: begin
                    bit_cnt_next = bit_cnt_reg + 3'd1;
                    if (bit_cnt_reg == 3'd7) begin
                        state_next = LS_WDATA_ACK;
                    end
                end
                LS_WDATA_ACK: begin
                    bit_cnt_next = 3'd0;
                    state_next = LS_WDATA;
                end
                LS_RDATA: begin
                    bit_cnt_next = bit_cnt_reg + 3'd1;
                    if (bit_cnt_reg == 3'd7) begin
                        state_next = LS_RDATA_ACK;
                        byte_sel_next = ~byte_sel_reg;
                    end
                end
                LS_RDATA_ACK: begin
                    bit_cnt_next = 3'd0;
                    if (!sda_in) begin // master acknowledge continues the word
                        state_next = LS_RDATA;
                    end else begin
                        state_next = LS_IDLE;
                        byte_sel_next = 1'b0;
                        req_tog_next = ~req_tog_reg;
                    end
                end
                default: begin
                    state_next = LS_IDLE;
                end
            endcase
        end
    end

    // protocol registers
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LS_IDLE;
            bit_cnt_reg <= 3'd0;
            shift_reg <= 8'h00;
            pointer_reg <= 8'h00;
            req_tog_reg <= 1'b0;
            byte_sel_reg <= 1'b0;
            rw_reg <= 1'b0;
            start_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            pointer_reg <= pointer_next;
            req_tog_reg <= req_tog_next;
            byte_sel_reg <= byte_sel_next;
            rw_reg <= rw_next;
            start_seen_reg <= start_seen_next;
        end
    end

    // data line drive, changed on the falling serial clock; snapshot is stable between requests
    always_comb begin
        tx_byte = byte_sel_reg ? snap_reg[15:8] : snap_reg[7:0];
        case (state_reg)
            LS_ADDR_ACK, LS_PTR_ACK, LS_WDATA_ACK: oe_next = 1'b1;
            LS_RDATA: oe_next = ~tx_byte[3'd7 - bit_cnt_reg];
            default: oe_next = 1'b0;
        endcase
    end

    always_ff @(negedge scl or negedge rst_n) begin
        if (!rst_n) begin
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
            out_reg <= 1'b0;
        end
    end

    assign sda_oe = oe_reg;
    assign sda_out = out_reg;
endmodule
